//--- hdl/regulator_setting_pkg.sv
// package for the regulator setting register bank: offsets, fields, defaults, types
// assumes byte-wide register port with 8-bit address supplied by the serial control block
//
// Behaviour
// - bank select picks primary or alternate code
// - rail a code bit 5 always one
// - rail b code bit 5 always one
// - rail a code above ceiling is discarded
// - ceiling guards both primary and alternate codes
// - ceiling read-only unless all-zeros or all-ones
// - rail a alternate bit 7 enables rail
// - rail a alternate bit 6 selects power save
// - rail b bit 7 enables rail
// - rail b bit 6 selects power save
// - power-on reset loads one-time-memory defaults
// - rail c bit 7 enables rail
// - rail c bit 6 selects power save
package regulator_setting_pkg;

    localparam logic [7:0] OFS_RAIL_A_PRIMARY   = 8'h19;
    localparam logic [7:0] OFS_RAIL_A_ALTERNATE = 8'h1a;
    localparam logic [7:0] OFS_RAIL_A_CEILING   = 8'h1b;
    localparam logic [7:0] OFS_RAIL_B_CONTROL   = 8'h1c;
    localparam logic [7:0] OFS_RAIL_C_CONTROL   = 8'h1d;

    localparam int BIT_ENABLE    = 7;
    localparam int BIT_LOW_POWER = 6;
    localparam int BIT_BANK_SEL  = 6;
    localparam int BIT_CODE_TOP  = 5;

    localparam logic [5:0] CODE_MASK_TOP = 6'h20;
    localparam logic [5:0] CEIL_OPEN_LO  = 6'h00;
    localparam logic [5:0] CEIL_OPEN_HI  = 6'h3f;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // default contents, standing for one variant's one-time memory
    localparam logic [7:0] DEF_RAIL_A_PRIMARY   = 8'h25;
    localparam logic [7:0] DEF_RAIL_A_ALTERNATE = 8'ha5;
    localparam logic [7:0] DEF_RAIL_A_CEILING   = 8'h3f;
    localparam logic [7:0] DEF_RAIL_B_CONTROL   = 8'ha5;
    localparam logic [7:0] DEF_RAIL_C_CONTROL   = 8'ha5;

    typedef struct packed {
        logic       enable;
        logic       low_power;
        logic [5:0] code;
    } rail_ctrl_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage : regulator_setting_pkg

//--- hdl/regulator_code_gate.sv
// judges whether a voltage code may be written against the ceiling
// assumes codes already carry the forced top bit
`timescale 1ns/10ps
`default_nettype none
module regulator_code_gate
    import regulator_setting_pkg::*;
(
    input  wire logic [5:0] i_code,     // code offered by the host
    input  wire logic [5:0] i_ceiling,  // current ceiling field
    output logic            o_accept    // high when the code may be stored
);
    assign o_accept = (i_code <= i_ceiling);
endmodule : regulator_code_gate
`default_nettype wire

//--- hdl/regulator_setting_registers.sv
// byte-wide register bank for three regulator rails
// assumes the serial control block delivers one-cycle read/write strobes in the i_mclk domain
`timescale 1ns/10ps
`default_nettype none
module regulator_setting_registers
    import regulator_setting_pkg::*;
(
    input  wire logic       i_mclk,          // 20 MHz clock
    input  wire logic       i_arst_n,        // power-on reset, active low
    input  wire reg_req_t   i_req,           // register write/read strobe, address, data
    output logic [7:0]      o_rdata,         // read data, registered
    output logic            o_rvalid,        // read data valid pulse
    output var rail_ctrl_t  o_rail_a,        // rail a enable, low power, code
    output var rail_ctrl_t  o_rail_b,        // rail b enable, low power, code
    output var rail_ctrl_t  o_rail_c         // rail c enable, low power, code
);

    function automatic logic [5:0] force_top(input logic [5:0] c);
        force_top = c | CODE_MASK_TOP;
    endfunction : force_top

    logic       a_bank_reg,  a_bank_next;
    logic [5:0] a_pri_reg,   a_pri_next;
    logic       a_en_reg,    a_en_next;
    logic       a_lp_reg,    a_lp_next;
    logic [5:0] a_alt_reg,   a_alt_next;
    logic [5:0] a_ceil_reg,  a_ceil_next;
    logic [7:0] b_reg,       b_next;
    logic [7:0] c_reg,       c_next;
    logic [7:0] rdata_reg,   rdata_next;
    logic       rvalid_reg,  rvalid_next;
    logic       code_ok;
    logic [5:0] wcode;

    assign wcode = force_top(i_req.wdata[5:0]);

    regulator_code_gate u_gate (
        .i_code    (wcode),
        .i_ceiling (a_ceil_reg),
        .o_accept  (code_ok)
    );

    always_comb begin
        a_bank_next = a_bank_reg;
        a_pri_next  = a_pri_reg;
        a_en_next   = a_en_reg;
        a_lp_next   = a_lp_reg;
        a_alt_next  = a_alt_reg;
        a_ceil_next = a_ceil_reg;
        b_next      = b_reg;
        c_next      = c_reg;
        if (i_req.wr) begin
            case (i_req.addr)
                OFS_RAIL_A_PRIMARY: begin
                    a_bank_next = i_req.wdata[BIT_BANK_SEL];
                    if (code_ok) begin
                        a_pri_next = wcode;
                    end
                end
                OFS_RAIL_A_ALTERNATE: begin
                    a_en_next = i_req.wdata[BIT_ENABLE];
                    a_lp_next = i_req.wdata[BIT_LOW_POWER];
                    if (code_ok) begin
                        a_alt_next = wcode;
                    end
                end
                OFS_RAIL_A_CEILING: begin
                    if (a_ceil_reg == CEIL_OPEN_LO || a_ceil_reg == CEIL_OPEN_HI) begin
                        a_ceil_next = force_top(i_req.wdata[5:0]);
                    end
                end
                OFS_RAIL_B_CONTROL: begin
                    b_next = {i_req.wdata[7:6], force_top(i_req.wdata[5:0])};
                end
                OFS_RAIL_C_CONTROL: begin
                    c_next = i_req.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rvalid_next = i_req.rd;
        rdata_next  = rdata_reg;
        if (i_req.rd) begin
            case (i_req.addr)
                OFS_RAIL_A_PRIMARY:   rdata_next = {1'h0, a_bank_reg, a_pri_reg};
                OFS_RAIL_A_ALTERNATE: rdata_next = {a_en_reg, a_lp_reg, a_alt_reg};
                OFS_RAIL_A_CEILING:   rdata_next = {2'h0, a_ceil_reg};
                OFS_RAIL_B_CONTROL:   rdata_next = b_reg;
                OFS_RAIL_C_CONTROL:   rdata_next = c_reg;
                default:              rdata_next = READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            a_bank_reg <= DEF_RAIL_A_PRIMARY[BIT_BANK_SEL];
            a_pri_reg  <= DEF_RAIL_A_PRIMARY[5:0] | CODE_MASK_TOP;
            a_en_reg   <= DEF_RAIL_A_ALTERNATE[BIT_ENABLE];
            a_lp_reg   <= DEF_RAIL_A_ALTERNATE[BIT_LOW_POWER];
            a_alt_reg  <= DEF_RAIL_A_ALTERNATE[5:0] | CODE_MASK_TOP;
            a_ceil_reg <= DEF_RAIL_A_CEILING[5:0] | CODE_MASK_TOP;
            b_reg      <= DEF_RAIL_B_CONTROL | {2'h0, CODE_MASK_TOP};
            c_reg      <= DEF_RAIL_C_CONTROL;
            rdata_reg  <= READ_UNMAPPED;
            rvalid_reg <= 1'h0;
        end else begin
            a_bank_reg <= a_bank_next;
            a_pri_reg  <= a_pri_next;
            a_en_reg   <= a_en_next;
            a_lp_reg   <= a_lp_next;
            a_alt_reg  <= a_alt_next;
            a_ceil_reg <= a_ceil_next;
            b_reg      <= b_next;
            c_reg      <= c_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign o_rdata  = rdata_reg;
    assign o_rvalid = rvalid_reg;

    // bank select high takes the alternate code
    assign o_rail_a.enable    = a_en_reg;
    assign o_rail_a.low_power = a_lp_reg;
    assign o_rail_a.code      = a_bank_reg ? a_alt_reg : a_pri_reg;
    assign o_rail_b.enable    = b_reg[BIT_ENABLE];
    assign o_rail_b.low_power = b_reg[BIT_LOW_POWER];
    assign o_rail_b.code      = force_top(b_reg[5:0]);
    assign o_rail_c.enable    = c_reg[BIT_ENABLE];
    assign o_rail_c.low_power = c_reg[BIT_LOW_POWER];
    assign o_rail_c.code      = c_reg[5:0];

endmodule : regulator_setting_registers
`default_nettype wire

//--- sim/regulator_setting_assertions.sv
// checker on the register bank ports
// assumes rising i_mclk, i_arst_n active low
`timescale 1ns/10ps
`default_nettype none
module regulator_setting_assertions
    import regulator_setting_pkg::*;
(
    input wire logic       i_mclk,   // clock
    input wire logic       i_arst_n, // reset, active low
    input wire reg_req_t   i_req,    // request
    input wire logic [7:0] o_rdata,  // read data
    input wire logic       o_rvalid, // read valid
    input wire rail_ctrl_t o_rail_a, // rail a
    input wire rail_ctrl_t o_rail_b, // rail b
    input wire rail_ctrl_t o_rail_c  // rail c
);
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (!i_arst_n);
    sequence s_wr(logic [7:0] a);
        i_req.wr && i_req.addr == a;
    endsequence
    a_rvalid_pulse: assert property (o_rvalid == $past(i_req.rd))
        else $error("read valid timing");
    a_code_a_top: assert property (o_rail_a.code[5]) else $error("rail a bit 5 low");
    a_code_b_top: assert property (o_rail_b.code[5]) else $error("rail b bit 5 low");
    a_alt_ctrl: assert property (s_wr(OFS_RAIL_A_ALTERNATE) |=>
        {o_rail_a.enable, o_rail_a.low_power} == $past(i_req.wdata[7:6])) else $error("rail a ctrl");
    a_b_ctrl: assert property (s_wr(OFS_RAIL_B_CONTROL) |=>
        {o_rail_b.enable, o_rail_b.low_power} == $past(i_req.wdata[7:6])) else $error("rail b ctrl");
    a_c_write: assert property (s_wr(OFS_RAIL_C_CONTROL) |=> o_rail_c == $past(i_req.wdata))
        else $error("rail c write");
    a_unused_read: assert property (i_req.rd && i_req.addr == OFS_RAIL_A_PRIMARY |=> !o_rdata[7])
        else $error("unused bit set");
    a_b_hold: assert property (!(i_req.wr && i_req.addr == OFS_RAIL_B_CONTROL) |=> $stable(o_rail_b))
        else $error("rail b moved");
endmodule : regulator_setting_assertions
bind regulator_setting_registers regulator_setting_assertions i_chk (.i_mclk(i_mclk),
    .i_arst_n(i_arst_n), .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_rail_a(o_rail_a), .o_rail_b(o_rail_b), .o_rail_c(o_rail_c));
`default_nettype wire

//--- sim/regulator_host_model.sv
// host side model issuing one-cycle strobes at the falling edge
// assumes the bank answers a read one cycle after its strobe
`timescale 1ns/10ps
`default_nettype none
module regulator_host_model
    import regulator_setting_pkg::*;
(
    input  wire logic       i_mclk,   // clock
    input  wire logic       i_rvalid, // read valid
    input  wire logic [7:0] i_rdata,  // read data
    output var  reg_req_t   o_req     // request
);
    initial o_req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        o_req <= '{1'h1, 1'h0, a, d & (a == OFS_RAIL_A_PRIMARY ? 8'h7f :
                  a == OFS_RAIL_A_CEILING ? 8'h3f : 8'hff)};
        @(negedge i_mclk);
        o_req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge i_mclk);
        o_req <= '{1'h0, 1'h1, a, 8'h00};
        @(negedge i_mclk);
        o_req <= '0;
        ok = i_rvalid;
        d = i_rdata;
    endtask : rd
endmodule : regulator_host_model
`default_nettype wire

//--- sim/regulator_setting_registers_bench.sv
// self-checking bench for the regulator register bank
// assumes the host model makes every request
`timescale 1ns/10ps
`default_nettype none
module regulator_setting_registers_bench;
    import regulator_setting_pkg::*;
    logic       i_mclk;
    logic       i_arst_n;
    reg_req_t   req;
    logic [7:0] rdata;
    logic       rvalid;
    rail_ctrl_t rail_a;
    rail_ctrl_t rail_b;
    rail_ctrl_t rail_c;
    int         n_fail = 0;
    int         tests_run = 0;
    logic [29:0] rows [9] = '{{8'h1c, 8'h05, 8'h25, 6'h25}, {8'h1c, 8'h5f, 8'h7f, 6'h25},
        {8'h1d, 8'h05, 8'h05, 6'h25}, {8'h1d, 8'hc0, 8'hc0, 6'h25}, {8'h1a, 8'h80, 8'ha0, 6'h25},
        {8'h1a, 8'h4a, 8'h6a, 6'h25}, {8'h19, 8'hff, 8'h7f, 6'h2a}, {8'h19, 8'h01, 8'h21, 6'h21},
        {8'h30, 8'hff, 8'h00, 6'h21}};
    logic [7:0] defs [5] = '{DEF_RAIL_A_PRIMARY, DEF_RAIL_A_ALTERNATE, DEF_RAIL_A_CEILING,
        DEF_RAIL_B_CONTROL, DEF_RAIL_C_CONTROL};
    regulator_setting_registers i_regulator_setting_registers (.i_mclk(i_mclk),
        .i_arst_n(i_arst_n), .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_rail_a(rail_a), .o_rail_b(rail_b), .o_rail_c(rail_c));
    regulator_host_model i_regulator_host_model (.i_mclk(i_mclk), .i_rvalid(rvalid),
        .i_rdata(rdata), .o_req(req));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    task automatic compare(input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : compare
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] got;
        logic       ok;
        i_regulator_host_model.rd(a, got, ok);
        if (ok !== 1'h1) begin
            n_fail++;
            wrap_up();
        end else compare(e, got);
    endtask : rd_chk
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        i_regulator_host_model.wr(a, d);
        rd_chk(a, e);
    endtask : wr_rd
    initial begin
        i_mclk = 1'h0;
        forever #25 i_mclk = ~i_mclk;
    end
    initial begin
        i_arst_n = 1'h0;
        repeat (3) @(posedge i_mclk);
        @(negedge i_mclk) i_arst_n = 1'h1;
        foreach (rows[k]) begin
            wr_rd(rows[k][29:22], rows[k][21:14], rows[k][13:6]);
            compare({2'h0, rows[k][5:0]}, {2'h0, rail_a.code});
        end
        wr_rd(OFS_RAIL_A_CEILING, 8'h25, 8'h25);
        wr_rd(OFS_RAIL_A_CEILING, 8'h3f, 8'h25);
        wr_rd(OFS_RAIL_A_PRIMARY, 8'h06, 8'h21);
        wr_rd(OFS_RAIL_A_ALTERNATE, 8'h1f, 8'h2a);
        wr_rd(OFS_RAIL_A_PRIMARY, 8'h05, 8'h25);
        compare(8'h25, rail_a);
        compare(8'h7f, rail_b);
        compare(8'hc0, rail_c);
        @(negedge i_mclk) i_arst_n = 1'h0;
        @(negedge i_mclk) i_arst_n = 1'h1;
        compare(8'ha5, rail_a);
        compare(8'ha5, rail_b);
        compare(8'ha5, rail_c);
        foreach (defs[k]) rd_chk(OFS_RAIL_A_PRIMARY + 8'(k), defs[k]);
        wrap_up();
    end
endmodule : regulator_setting_registers_bench
`default_nettype wire
